//--- cx_exec_unit.sv
// Purpose: execution unit for loads, special moves, multiply, or, stream put, reverse subtract
// Assumes: one clock; memory and link peers run on the same clock
// Notes:   software issues one instruction per bus write to the instruction register
`timescale 1ns/10ps

// Overview of operation
// - indexed word load: address is sum of two registers, word aligned, waits until memory returns the word
// - immediate word load: base plus sign-extended constant, word aligned
// - reading a special register copies it into the destination in one cycle
// - exception address and status readable only from version 3.00a
// - status clear returns old word, clears bits marked in the immediate
// - status set returns old word, sets bits marked in the immediate
// - status set and clear touch only the low fourteen status bits
// - status set and clear valid only with option on and version 2.10.a or later
// - status write by move-to-special takes effect one cycle later
// - move-to-special writes only the status word, never the others
// - multiply keeps low word of 64-bit product, three cycles, optional unit
// - immediates sign-extend unless prefixed, then prefix gives the upper half
// - or of source with register or constant, one cycle
// - blocking put stalls until the link takes the word
// - non-blocking put never stalls, carry is one when link was full
// - data puts drive control bit zero, control puts drive it one
// - put completes in two cycles unless blocking against a full link
// - reverse subtract adds inverted first operand plus one or carry
// - keep bit set leaves carry alone, else carry takes adder carry-out
// - carry-in bit selects carry flag as adder carry-in
// - immediate reverse subtract honours the same keep and carry-in bits
// - carry after subtraction is the inverse of borrow
module cx_exec_unit #(
  parameter int          NUM_GPR        = 32,
  parameter logic [15:0] CORE_VERSION   = 16'h0300,
  parameter bit          HAS_STATUS_OP  = 1'b1,
  parameter bit          HAS_MUL        = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             memRead,
  output logic [31:0]      memAddress,
  input  wire logic [31:0] memReadData,
  input  wire logic        memReadValid,
  output logic             linkWrite,
  output logic [31:0]      linkData,
  output logic             linkCtrl,
  input  wire logic        linkFull
);

  typedef struct packed {
    cx_pkg::cx_state_t        st;
    logic [31:0]              instr;
    logic [NUM_GPR-1:0][31:0] gpr;
    logic [31:0]              msw;
    logic [31:0]              pc;
    logic [31:0]              exa;
    logic [31:0]              exs;
    logic                     mswPend;
    logic [31:0]              mswNew;
    logic                     immLock;
    logic [15:0]              immHi;
    logic                     illegal;
    logic                     waitReq;
    logic [31:0]              rdata;
    logic                     memRd;
    logic [31:0]              memAddr;
    logic                     lnkWr;
    logic [31:0]              lnkData;
    logic                     lnkCtrl;
    logic                     mulGo;
    logic [31:0]              mulA;
    logic [31:0]              mulB;
  } cx_exec_st_t;

  cx_exec_st_t stReg;
  cx_exec_st_t stNext;

  logic        mulDone;
  logic [31:0] mulProd;

  cx_mul_pipe #(
    .STAGES (cx_pkg::MUL_PIPE)
  ) mulUnit (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (stReg.mulGo),
    .opA     (stReg.mulA),
    .opB     (stReg.mulB),
    .done    (mulDone),
    .product (mulProd)
  );

  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[8*i +: 8] = newVal[8*i +: 8];
    end
    return res;
  endfunction

  logic [5:0]  opc;
  logic [4:0]  rdIdx;
  logic [4:0]  aIdx;
  logic [4:0]  bIdx;
  logic [15:0] imm16;
  logic [31:0] immVal;
  logic [31:0] opA;
  logic [31:0] opB;
  logic [32:0] subSum;
  logic        subCin;
  logic        excRegsOk;
  logic        statusOpOk;
  logic [4:0]  busIdx;
  logic        busGpr;
  logic        nonBlock;

  always_comb
  begin
    opc = stReg.instr[31:26];
    rdIdx = stReg.instr[25:21];
    aIdx = stReg.instr[20:16];
    bIdx = stReg.instr[15:11];
    imm16 = stReg.instr[15:0];
    // a locked prefix supplies the upper half instead of sign bits
    if (stReg.immLock)
      immVal = {stReg.immHi, imm16};
    else
      immVal = {{16{imm16[15]}}, imm16};
    opA = (32'(aIdx) < NUM_GPR) ? stReg.gpr[aIdx] : cx_pkg::WORD_RST;
    if (opc[cx_pkg::OP_TYPEB_POS])
      opB = immVal;
    else
      opB = (32'(bIdx) < NUM_GPR) ? stReg.gpr[bIdx] : cx_pkg::WORD_RST;
    if (opc[cx_pkg::OP_CIN_POS])
      subCin = stReg.msw[cx_pkg::CARRY_POS];
    else
      subCin = 1'b1;
    // carry-out of b + ~a + cin is the inverse of borrow
    subSum = {1'b0, opB} + {1'b0, ~opA} + {32'h0000_0000, subCin};
    excRegsOk = CORE_VERSION >= cx_pkg::VER_EXC_REGS;
    statusOpOk = HAS_STATUS_OP && (CORE_VERSION >= cx_pkg::VER_STATUS_OP);
    busGpr = avs_address[cx_pkg::GPR_WIN_BIT];
    busIdx = avs_address[6:2];
    nonBlock = stReg.instr[cx_pkg::PUT_NB_POS];
  end

  always_comb
  begin
    stNext = stReg;
    stNext.memRd = 1'b0;
    stNext.mulGo = 1'b0;
    // status written by a move lands one edge after the move itself
    if (stReg.mswPend)
    begin
      stNext.msw = stReg.mswNew;
      stNext.mswPend = 1'b0;
    end
    case (stReg.st)
      cx_pkg::ST_IDLE:
      begin
        stNext.waitReq = 1'b1;
        if (avs_write && avs_address == cx_pkg::ADDR_INSTR)
        begin
          stNext.instr = avs_writedata;
          stNext.st = cx_pkg::ST_RUN;
        end
        else if (avs_read || avs_write)
        begin
          stNext.rdata = cx_pkg::WORD_RST;
          if (busGpr)
          begin
            if (32'(busIdx) < NUM_GPR)
            begin
              stNext.rdata = stReg.gpr[busIdx];
              if (avs_write)
                stNext.gpr[busIdx] = mergeBytes(stReg.gpr[busIdx], avs_writedata,
                                                avs_byteenable);
            end
          end
          else
          begin
            case (avs_address)
              cx_pkg::ADDR_INSTR:
                stNext.rdata = stReg.instr;
              cx_pkg::ADDR_STATUS:
              begin
                stNext.rdata[cx_pkg::STAT_ILL_POS] = stReg.illegal;
                stNext.rdata[cx_pkg::STAT_LOCK_POS] = stReg.immLock;
                if (avs_write && avs_byteenable[0] && avs_writedata[cx_pkg::STAT_ILL_POS])
                  stNext.illegal = 1'b0;
              end
              cx_pkg::ADDR_MSW:
              begin
                stNext.rdata = stReg.msw;
                if (avs_write)
                  stNext.msw = mergeBytes(stReg.msw, avs_writedata, avs_byteenable);
              end
              cx_pkg::ADDR_PC:
              begin
                stNext.rdata = stReg.pc;
                if (avs_write)
                  stNext.pc = mergeBytes(stReg.pc, avs_writedata, avs_byteenable);
              end
              cx_pkg::ADDR_EXA:
              begin
                stNext.rdata = stReg.exa;
                if (avs_write)
                  stNext.exa = mergeBytes(stReg.exa, avs_writedata, avs_byteenable);
              end
              cx_pkg::ADDR_EXS:
              begin
                stNext.rdata = stReg.exs;
                if (avs_write)
                  stNext.exs = mergeBytes(stReg.exs, avs_writedata, avs_byteenable);
              end
              default:
                stNext.rdata = cx_pkg::WORD_RST;
            endcase
          end
          stNext.waitReq = 1'b0;
          stNext.st = cx_pkg::ST_ACK;
        end
      end
      cx_pkg::ST_RUN:
      begin
        stNext.pc = stReg.pc + cx_pkg::PC_STEP;
        stNext.immLock = 1'b0;
        stNext.waitReq = 1'b0;
        stNext.st = cx_pkg::ST_ACK;
        if (opc == cx_pkg::OP_IMM)
        begin
          stNext.immLock = 1'b1;
          stNext.immHi = imm16;
        end
        else if (opc == cx_pkg::OP_OR || opc == cx_pkg::OP_ORI)
          stNext.gpr[rdIdx] = opA | opB;
        else if (opc[5:4] == 2'b00 && opc[0])
        begin
          stNext.gpr[rdIdx] = subSum[31:0];
          if (!opc[cx_pkg::OP_KEEP_POS])
            stNext.msw[cx_pkg::CARRY_POS] = subSum[32];
        end
        else if (opc == cx_pkg::OP_LDW || opc == cx_pkg::OP_LDWI)
        begin
          // low two address bits are forced to zero
          stNext.memAddr = (opA + opB) & cx_pkg::WORD_MASK;
          stNext.memRd = 1'b1;
          stNext.waitReq = 1'b1;
          stNext.st = cx_pkg::ST_LOAD;
        end
        else if ((opc == cx_pkg::OP_MUL || opc == cx_pkg::OP_MULI) && HAS_MUL)
        begin
          stNext.mulA = opA;
          stNext.mulB = opB;
          stNext.mulGo = 1'b1;
          stNext.waitReq = 1'b1;
          stNext.st = cx_pkg::ST_MUL;
        end
        else if (opc == cx_pkg::OP_PUT)
        begin
          stNext.lnkData = opA;
          stNext.lnkCtrl = stReg.instr[cx_pkg::PUT_CTRL_POS];
          stNext.lnkWr = 1'b1;
          stNext.waitReq = 1'b1;
          stNext.st = cx_pkg::ST_PUT;
        end
        else if (opc == cx_pkg::OP_SPEC)
        begin
          case (stReg.instr[15:14])
            cx_pkg::SUB_MFS:
            begin
              if (stReg.instr[2:0] == cx_pkg::SEL_PC)
                stNext.gpr[rdIdx] = stReg.pc;
              else if (stReg.instr[2:0] == cx_pkg::SEL_MSW)
                stNext.gpr[rdIdx] = stReg.msw;
              else if (stReg.instr[2:0] == cx_pkg::SEL_EXA && excRegsOk)
                stNext.gpr[rdIdx] = stReg.exa;
              else if (stReg.instr[2:0] == cx_pkg::SEL_EXS && excRegsOk)
                stNext.gpr[rdIdx] = stReg.exs;
              else
                stNext.illegal = 1'b1;
            end
            cx_pkg::SUB_MTS:
            begin
              // program counter and exception registers are never targets
              if (stReg.instr[2:0] == cx_pkg::SEL_MSW)
              begin
                stNext.mswPend = 1'b1;
                stNext.mswNew = opA;
              end
              else
                stNext.illegal = 1'b1;
            end
            cx_pkg::SUB_SET:
            begin
              if (statusOpOk)
              begin
                stNext.gpr[rdIdx] = stReg.msw;
                stNext.msw = stReg.msw | ({18'h0, imm16[13:0]} & cx_pkg::STATUS_OP_MASK);
              end
              else
                stNext.illegal = 1'b1;
            end
            cx_pkg::SUB_CLR:
            begin
              if (statusOpOk)
              begin
                stNext.gpr[rdIdx] = stReg.msw;
                stNext.msw = stReg.msw & ~({18'h0, imm16[13:0]} & cx_pkg::STATUS_OP_MASK);
              end
              else
                stNext.illegal = 1'b1;
            end
            default:
              stNext.illegal = 1'b1;
          endcase
        end
        else
          stNext.illegal = 1'b1;
      end
      cx_pkg::ST_LOAD:
      begin
        if (memReadValid)
        begin
          stNext.gpr[rdIdx] = memReadData;
          stNext.waitReq = 1'b0;
          stNext.st = cx_pkg::ST_ACK;
        end
      end
      cx_pkg::ST_MUL:
      begin
        if (mulDone)
        begin
          stNext.gpr[rdIdx] = mulProd;
          stNext.waitReq = 1'b0;
          stNext.st = cx_pkg::ST_ACK;
        end
      end
      cx_pkg::ST_PUT:
      begin
        // word and control bit are left untouched while the link is full
        if (nonBlock || !linkFull)
        begin
          if (nonBlock)
            stNext.msw[cx_pkg::CARRY_POS] = linkFull;
          stNext.lnkWr = 1'b0;
          stNext.waitReq = 1'b0;
          stNext.st = cx_pkg::ST_ACK;
        end
      end
      cx_pkg::ST_ACK:
      begin
        stNext.waitReq = 1'b1;
        stNext.st = cx_pkg::ST_IDLE;
      end
      default:
      begin
        stNext.waitReq = 1'b1;
        stNext.st = cx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stReg <= '0;
      stReg.st <= cx_pkg::ST_IDLE;
      stReg.msw <= cx_pkg::MSW_RST;
      stReg.pc <= cx_pkg::PC_RST;
      stReg.waitReq <= 1'b1;
    end
    else
      stReg <= stNext;
  end

  // outputs come straight from state flops
  assign avs_readdata = stReg.rdata;
  assign avs_waitrequest = stReg.waitReq;
  assign memRead = stReg.memRd;
  assign memAddress = stReg.memAddr;
  assign linkWrite = stReg.lnkWr;
  assign linkData = stReg.lnkData;
  assign linkCtrl = stReg.lnkCtrl;

endmodule

//--- cx_exec_unit_checker.sv
// Purpose: concurrent checks on the execution unit ports
// Assumes: one clock, reset_n active low
// Notes:   bound into every cx_exec_unit instance
`timescale 1ns/10ps
module cx_exec_checker (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        memRead,
  input wire logic [31:0] memAddress,
  input wire logic [31:0] memReadData,
  input wire logic        memReadValid,
  input wire logic        linkWrite,
  input wire logic [31:0] linkData,
  input wire logic        linkCtrl,
  input wire logic        linkFull
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [5:0] op;
  logic       issue;
  logic       nb;
  assign op    = avs_writedata[31:26];
  assign issue = avs_write && avs_address == cx_pkg::ADDR_INSTR;
  assign nb    = avs_writedata[cx_pkg::PUT_NB_POS];

  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_OR_LAT: assert property ($rose(avs_write) && issue && op == cx_pkg::OP_OR
    |-> ##1 avs_waitrequest ##1 !avs_waitrequest) else $error("or answer late");
  AST_MUL_LAT: assert property ($rose(avs_write) && issue && op == cx_pkg::OP_MUL
    |-> ##1 avs_waitrequest[*3] ##1 !avs_waitrequest) else $error("multiply answer late");
  AST_LOAD_ALIGN: assert property (memRead |-> memAddress[1:0] == 2'b00)
    else $error("load address not word aligned");
  AST_LOAD_PULSE: assert property (memRead |=> !memRead && avs_waitrequest)
    else $error("load request not a single pulse");
  AST_LOAD_DONE: assert property (memReadValid |=> !avs_waitrequest)
    else $error("load not answered after data");
  AST_PUT_START: assert property ($rose(avs_write) && issue && op == cx_pkg::OP_PUT
    |-> ##2 linkWrite && linkCtrl == avs_writedata[cx_pkg::PUT_CTRL_POS])
    else $error("put start or control bit wrong");
  AST_PUT_HOLD: assert property (linkWrite && linkFull && !nb
    |=> linkWrite && $stable(linkData) && $stable(linkCtrl)) else $error("stalled put moved");
  AST_PUT_TAKEN: assert property (linkWrite && !linkFull |=> !linkWrite && !avs_waitrequest)
    else $error("accepted put not completed");
  AST_NB_ONE: assert property (linkWrite && nb |=> !linkWrite)
    else $error("non-blocking put stalled");
endmodule

bind cx_exec_unit cx_exec_checker i_cx_exec_checker (.clock(clock), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .memRead(memRead),
  .memAddress(memAddress), .memReadData(memReadData), .memReadValid(memReadValid),
  .linkWrite(linkWrite), .linkData(linkData), .linkCtrl(linkCtrl), .linkFull(linkFull));

//--- cx_exec_unit_tb.sv
// Purpose: self-checking bench for the execution unit
// Assumes: Avalon master tasks, partner model on memory and link
// Notes:   table of plain ops first, stalls and status ops by hand
`timescale 1ns/10ps
module cx_exec_unit_tb;
  typedef struct {
    logic [31:0] ins;
    logic [31:0] rd;
    logic        c;
  } cx_row_t;
  logic        clock, reset_n, avs_read, avs_write, avs_waitrequest, memRead, memReadValid;
  logic        linkWrite, linkCtrl, linkFull, holdFull, lastCtrl;
  logic [7:0]  avs_address, nTaken;
  logic [3:0]  avs_byteenable, memDelay;
  logic [31:0] avs_writedata, avs_readdata, memAddress, memReadData, linkData, lastData, q;
  int          n_errors, cmp_count, cyc;
  cx_row_t     rows[13];

  cx_exec_unit i_cx_exec_unit (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .memRead(memRead), .memAddress(memAddress),
    .memReadData(memReadData), .memReadValid(memReadValid), .linkWrite(linkWrite),
    .linkData(linkData), .linkCtrl(linkCtrl), .linkFull(linkFull));
  cx_far_model i_cx_far_model (.clock(clock), .reset_n(reset_n), .memRead(memRead),
    .memAddress(memAddress), .linkWrite(linkWrite), .linkData(linkData),
    .linkCtrl(linkCtrl), .holdFull(holdFull), .memDelay(memDelay),
    .memReadData(memReadData), .memReadValid(memReadValid), .linkFull(linkFull),
    .lastData(lastData), .lastCtrl(lastCtrl), .nTaken(nTaken));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  function automatic logic [31:0] enc(input logic [5:0] op, input logic [4:0] a,
                                      input logic [15:0] lo);
    return {op, 5'h03, a, lo};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic run(input logic [31:0] i);
    bus(1'b1, cx_pkg::ADDR_INSTR, i);
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      conclude();
    end
  end

  initial
  begin
    {reset_n, avs_read, avs_write, holdFull, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    memDelay = 4'h0;
    {n_errors, cmp_count, cyc} = '0;
    rows[0]  = '{enc(cx_pkg::OP_OR, 1, 16'h1000), 32'h0000_0007, 1'b0};
    rows[1]  = '{enc(cx_pkg::OP_ORI, 1, 16'h8000), 32'hFFFF_8005, 1'b0};
    rows[2]  = '{enc(6'h09, 1, 16'h0010), 32'h0000_000B, 1'b1};
    rows[3]  = '{enc(6'h03, 1, 16'h1000), 32'hFFFF_FFFE, 1'b0};
    rows[4]  = '{enc(6'h07, 1, 16'h1000), 32'hFFFF_FFFD, 1'b0};
    rows[5]  = '{enc(6'h01, 2, 16'h0800), 32'h0000_0002, 1'b1};
    rows[6]  = '{enc(6'h05, 1, 16'h1000), 32'hFFFF_FFFE, 1'b1};
    rows[7]  = '{enc(6'h0F, 1, 16'h0010), 32'h0000_000B, 1'b1};
    rows[8]  = '{enc(cx_pkg::OP_MUL, 1, 16'h1000), 32'h0000_000F, 1'b1};
    rows[9]  = '{enc(cx_pkg::OP_MULI, 1, 16'hFFFF), 32'hFFFF_FFFB, 1'b1};
    rows[10] = '{enc(cx_pkg::OP_LDW, 1, 16'h0800), 32'h5A5A_A5AD, 1'b1};
    rows[11] = '{enc(cx_pkg::OP_LDWI, 1, 16'hFFFF), 32'h5A5A_A5A1, 1'b1};
    rows[12] = '{enc(cx_pkg::OP_SPEC, 0, 16'h8001), 32'h0000_0004, 1'b1};
    repeat (2) @(posedge clock);
    chk("reset wait", 32'h1, {31'h0, avs_waitrequest});
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    bus(1'b1, 8'h84, 32'h5);
    bus(1'b1, 8'h88, 32'h3);
    foreach (rows[i])
    begin
      run(rows[i].ins);
      rdchk("dest", 8'h8C, rows[i].rd);
      bus(1'b0, cx_pkg::ADDR_MSW, 32'h0);
      chk("carry", {31'h0, rows[i].c}, {31'h0, q[cx_pkg::CARRY_POS]});
    end
    // slow memory answer
    memDelay <= 4'h7;
    bus(1'b1, 8'h8C, 32'h0);
    run(rows[10].ins);
    rdchk("slow load", 8'h8C, 32'h5A5A_A5AD);
    run(enc(cx_pkg::OP_IMM, 0, 16'h1234));
    run(enc(cx_pkg::OP_ORI, 4, 16'h5678));
    rdchk("prefix", 8'h8C, 32'h1234_5678);
    bus(1'b1, cx_pkg::ADDR_MSW, 32'h0);
    run(enc(cx_pkg::OP_SPEC, 0, 16'h3FFF));
    rdchk("set", cx_pkg::ADDR_MSW, 32'h0000_3FFF);
    bus(1'b1, cx_pkg::ADDR_MSW, 32'hFFFF_FFFF);
    run(enc(cx_pkg::OP_SPEC, 0, 16'h7FFF));
    rdchk("old word", 8'h8C, 32'hFFFF_FFFF);
    rdchk("clear", cx_pkg::ADDR_MSW, 32'hFFFF_C000);
    run(enc(cx_pkg::OP_SPEC, 1, 16'hC001));
    rdchk("move to status", cx_pkg::ADDR_MSW, 32'h0000_0005);
    bus(1'b1, cx_pkg::ADDR_PC, 32'h0000_0100);
    run(enc(cx_pkg::OP_SPEC, 1, 16'hC000));
    rdchk("pc kept", cx_pkg::ADDR_PC, 32'h0000_0104);
    rdchk("illegal flag", cx_pkg::ADDR_STATUS, 32'h1);
    bus(1'b1, cx_pkg::ADDR_STATUS, 32'h1);
    rdchk("flag cleared", cx_pkg::ADDR_STATUS, 32'h0);
    bus(1'b1, cx_pkg::ADDR_EXA, 32'hCAFE_0000);
    run(enc(cx_pkg::OP_SPEC, 0, 16'h8003));
    rdchk("fault address", 8'h8C, 32'hCAFE_0000);
    rdchk("unmapped", 8'h40, 32'h0);
    holdFull <= 1'b1;
    fork
      run(enc(cx_pkg::OP_PUT, 1, 16'h0000));
      begin
        repeat (9) @(posedge clock);
        chk("stalled count", 32'h0, {24'h0, nTaken});
        holdFull <= 1'b0;
      end
    join
    chk("put data", 32'h5, lastData);
    chk("put ctrl", 32'h0, {31'h0, lastCtrl});
    // carry starts set here, so the free put must clear it and the full one set it again
    run(enc(cx_pkg::OP_PUT, 1, 16'h8000));
    rdchk("free carry", cx_pkg::ADDR_MSW, 32'h0000_0001);
    holdFull <= 1'b1;
    run(enc(cx_pkg::OP_PUT, 1, 16'hC000));
    rdchk("full carry", cx_pkg::ADDR_MSW, 32'h0000_0005);
    holdFull <= 1'b0;
    run(enc(cx_pkg::OP_PUT, 2, 16'h4000));
    chk("ctrl put", 32'h1, {31'h0, lastCtrl});
    chk("taken count", 32'h3, {24'h0, nTaken});
    conclude();
  end
endmodule

//--- cx_far_model.sv
// Purpose: memory responder and stream consumer beside the execution unit
// Assumes: same clock as the unit, one read outstanding
// Notes:   read bus shows inverted data when no word is returned
`timescale 1ns/10ps
module cx_far_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        memRead,
  input  wire logic [31:0] memAddress,
  input  wire logic        linkWrite,
  input  wire logic [31:0] linkData,
  input  wire logic        linkCtrl,
  input  wire logic        holdFull,
  input  wire logic [3:0]  memDelay,
  output logic [31:0]      memReadData,
  output logic             memReadValid,
  output logic             linkFull,
  output logic [31:0]      lastData,
  output logic             lastCtrl,
  output logic [7:0]       nTaken
);
  logic        pend;
  logic        fire;
  logic [3:0]  waitCnt;
  logic [31:0] addr;
  assign linkFull = holdFull;
  assign fire     = pend && waitCnt == 4'h0;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      {pend, waitCnt, addr, memReadValid, memReadData} <= '0;
      {lastData, lastCtrl, nTaken} <= '0;
    end
    else
    begin
      memReadValid <= fire;
      // stale data would hide a missing valid check
      memReadData  <= fire ? (addr ^ 32'h5A5A_A5A5) : ~memReadData;
      waitCnt      <= memRead ? memDelay : waitCnt - 4'h1;
      pend         <= memRead || (pend && waitCnt != 4'h0);
      if (memRead)
        addr <= memAddress;
      if (linkWrite && !linkFull)
      begin
        lastData <= linkData;
        lastCtrl <= linkCtrl;
        nTaken   <= nTaken + 8'h01;
      end
    end
endmodule

//--- cx_mul_pipe.sv
// Purpose: pipelined 32x32 multiplier keeping the low word
// Assumes: start is a one-cycle pulse from the same clock
// Notes:   done pulses STAGES cycles after start
`timescale 1ns/10ps
module cx_mul_pipe #(
  parameter int STAGES = cx_pkg::MUL_PIPE
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic [31:0] opA,
  input  wire logic [31:0] opB,
  output logic             done,
  output logic [31:0]      product
);

  typedef struct packed {
    logic [STAGES-1:0]       vld;
    logic [STAGES-1:0][31:0] prod;
  } cx_mul_st_t;

  cx_mul_st_t stReg;
  cx_mul_st_t stNext;
  logic [63:0] fullProd;

  always_comb
  begin
    stNext = stReg;
    fullProd = 64'(opA) * 64'(opB);
    // high word is discarded
    stNext.vld[0] = start;
    stNext.prod[0] = fullProd[31:0];
    for (int i = 1; i < STAGES; i++)
    begin
      stNext.vld[i] = stReg.vld[i-1];
      stNext.prod[i] = stReg.prod[i-1];
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      stReg <= '0;
    else
      stReg <= stNext;
  end

  assign done = stReg.vld[STAGES-1];
  assign product = stReg.prod[STAGES-1];

endmodule

//--- cx_pkg.sv
// Purpose: shared constants and types for the execution unit
// Assumes: 32-bit words, bit 0 is the least significant bit
// Notes:   opcode values and register offsets are fixed here, except the reverse subtract opcodes, decoded by bit pattern in the unit
package cx_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_INSTR    = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_MSW      = 8'h08;
  localparam logic [7:0] ADDR_PC       = 8'h0C;
  localparam logic [7:0] ADDR_EXA      = 8'h10;
  localparam logic [7:0] ADDR_EXS      = 8'h14;
  localparam int         GPR_WIN_BIT   = 7;

  // reset values
  localparam logic [31:0] MSW_RST      = 32'h0000_0000;
  localparam logic [31:0] PC_RST       = 32'h0000_0000;
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;

  // opcodes, instruction bits 31:26
  localparam logic [5:0] OP_OR         = 6'h20;
  localparam logic [5:0] OP_ORI        = 6'h28;
  localparam logic [5:0] OP_MUL        = 6'h10;
  localparam logic [5:0] OP_MULI       = 6'h18;
  localparam logic [5:0] OP_IMM        = 6'h2C;
  localparam logic [5:0] OP_LDW        = 6'h32;
  localparam logic [5:0] OP_LDWI       = 6'h3A;
  localparam logic [5:0] OP_SPEC       = 6'h25;
  localparam logic [5:0] OP_PUT        = 6'h1B;

  // special group sub-operation, instruction bits 15:14
  localparam logic [1:0] SUB_SET       = 2'h0;
  localparam logic [1:0] SUB_CLR       = 2'h1;
  localparam logic [1:0] SUB_MFS       = 2'h2;
  localparam logic [1:0] SUB_MTS       = 2'h3;

  // special_sel codes, instruction bits 2:0
  localparam logic [2:0] SEL_PC        = 3'h0;
  localparam logic [2:0] SEL_MSW       = 3'h1;
  localparam logic [2:0] SEL_EXA       = 3'h3;
  localparam logic [2:0] SEL_EXS       = 3'h5;

  // field positions
  localparam int         OP_TYPEB_POS  = 3;
  localparam int         OP_KEEP_POS   = 2;
  localparam int         OP_CIN_POS    = 1;
  localparam int         PUT_NB_POS    = 15;
  localparam int         PUT_CTRL_POS  = 14;
  localparam int         CARRY_POS     = 2;
  localparam int         STAT_ILL_POS  = 0;
  localparam int         STAT_LOCK_POS = 1;

  localparam logic [31:0] STATUS_OP_MASK = 32'h0000_3FFF;
  localparam logic [31:0] WORD_MASK      = 32'hFFFF_FFFC;
  localparam logic [31:0] PC_STEP        = 32'h0000_0004;

  // core versions as 8.8 fixed codes
  localparam logic [15:0] VER_STATUS_OP = 16'h0210;
  localparam logic [15:0] VER_EXC_REGS  = 16'h0300;

  // cycle counts
  localparam int         MUL_CYCLES    = 3;
  localparam int         MUL_PIPE      = MUL_CYCLES - 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_LOAD,
    ST_MUL,
    ST_PUT,
    ST_ACK
  } cx_state_t;

endpackage
